// ### hdl/pba_map.svh
// Bus commands, address window and timing counts for the bus agent.
`ifndef PBA_MAP_SVH
`define PBA_MAP_SVH
`define PBA_CMD_MRD     4'h6
`define PBA_CMD_MWR     4'h7
`define PBA_CMD_CFGRD   4'hA
`define PBA_CMD_CFGWR   4'hB
`define PBA_BAR_BASE    32'h0001_0000
`define PBA_BAR_MASK    32'hFFFF_F000
`define PBA_MABORT_CLKS 5
`define PBA_SYNC_W      47
`endif

// ### hdl/pba_pkg.sv
// State types of the bus agent.
package pba_pkg;
    typedef enum logic [3:0] {
        T_IDLE = 4'b0001,
        T_WAIT = 4'b0010,
        T_DATA = 4'b0100,
        T_TURN = 4'b1000
    } pba_tgt_e;
    typedef enum logic [3:0] {
        M_IDLE = 4'b0001,
        M_REQ  = 4'b0010,
        M_ADDR = 4'b0100,
        M_DATA = 4'b1000
    } pba_mst_e;
endpackage

// ### hdl/pba_agent.sv
// Bus agent: claimed target accesses and single-phase master cycles.
`timescale 1ns/10ps
`include "pba_map.svh"
// Operation
// - AD carries address, then data
// - C/BE carries command, then byte enables
// - C/BE driven only while bus master
// - PAR is even parity over AD, C/BE
// - PAR driven one clock after phase
// - Master drives FRAME for the transaction
// - Master asserts IRDY when data ready
// - Target asserts TRDY when data ready
// - Target asserts STOP to end transaction
// - Configuration cycles claimed only with IDSEL
// - DEVSEL asserted after own address decode
// - REQ requests bus, floats during reset
// - PERR reports data parity errors
// - SERR pulled low on address parity error
// - INTA held low while sources pending
// - Bus signals change on bus clock rise; INTA enable and bus reset act on any system clock
// - Bus reset returns interface to idle
module pba_agent #(
    parameter int          N_IRQ    = 4,
    parameter logic [31:0] BAR_BASE = `PBA_BAR_BASE,
    parameter logic [31:0] BAR_MASK = `PBA_BAR_MASK,
    parameter int          MABORT   = `PBA_MABORT_CLKS
) (
    // System clock and reset.
    input  wire logic             i_sys_clk,
    input  wire logic             i_rst_b,
    // Bus clock and bus reset pins.
    input  wire logic             i_pci_clk,
    input  wire logic             i_pci_rst_b,
    // Address, command and parity.
    input  wire logic [31:0]      i_ad,
    output logic      [31:0]      o_ad,
    output logic                  o_ad_oe_b,
    input  wire logic [3:0]       i_cbe_b,
    output logic      [3:0]       o_cbe_b,
    output logic                  o_cbe_oe_b,
    input  wire logic             i_par,
    output logic                  o_par,
    output logic                  o_par_oe_b,
    // Transaction control.
    input  wire logic             i_frame_b,
    output logic                  o_frame_b,
    output logic                  o_frame_oe_b,
    input  wire logic             i_irdy_b,
    output logic                  o_irdy_b,
    output logic                  o_irdy_oe_b,
    input  wire logic             i_trdy_b,
    output logic                  o_trdy_b,
    output logic                  o_trdy_oe_b,
    input  wire logic             i_stop_b,
    output logic                  o_stop_b,
    output logic                  o_stop_oe_b,
    input  wire logic             i_devsel_b,
    output logic                  o_devsel_b,
    output logic                  o_devsel_oe_b,
    input  wire logic             i_idsel,
    // Arbitration.
    output logic                  o_req_b,
    output logic                  o_req_oe_b,
    input  wire logic             i_gnt_b,
    // Error and interrupt pins.
    input  wire logic             i_perr_b,
    output logic                  o_perr_b,
    output logic                  o_perr_oe_b,
    output logic                  o_serr_b,
    output logic                  o_serr_oe_b,
    input  wire logic [N_IRQ-1:0] i_irq_src,
    output logic                  o_inta_b,
    output logic                  o_inta_oe_b,
    // Target user side.
    output logic                  o_tgt_stb,
    output logic                  o_tgt_wr,
    output logic                  o_tgt_cfg,
    output logic      [31:0]      o_tgt_addr,
    output logic      [31:0]      o_tgt_wdata,
    output logic      [3:0]       o_tgt_be_b,
    input  wire logic [31:0]      i_tgt_rdata,
    // Master user side.
    input  wire logic             i_mst_go,
    input  wire logic             i_mst_wr,
    input  wire logic [31:0]      i_mst_addr,
    input  wire logic [31:0]      i_mst_wdata,
    input  wire logic [3:0]       i_mst_be_b,
    output logic                  o_mst_busy,
    output logic                  o_mst_done,
    output logic                  o_mst_err,
    output logic      [31:0]      o_mst_rdata
);
    localparam int CW = $clog2(MABORT + 1);

    if (N_IRQ < 1 || MABORT < 2) begin : g_chk
        $error("pba_agent: N_IRQ must be at least 1 and MABORT at least 2");
    end

    function automatic logic par36(input logic [35:0] v);
        return ^v;
    endfunction

    // Two-stage synchroniser, plus a third stage holding the value seen before the clock edge.
    logic [`PBA_SYNC_W-1:0] sy1;
    logic [`PBA_SYNC_W-1:0] sy2;
    logic [`PBA_SYNC_W-1:0] sy3;
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sy1 <= '1;
            sy2 <= '1;
            sy3 <= '1;
        end else begin
            sy1 <= {i_pci_clk, i_pci_rst_b, i_ad, i_cbe_b, i_par, i_frame_b, i_irdy_b, i_trdy_b,
                    i_stop_b, i_devsel_b, i_idsel, i_gnt_b, i_perr_b};
            sy2 <= sy1;
            sy3 <= sy2;
        end
    end

    wire logic        rise     = sy2[46] & ~sy3[46];
    wire logic        b_rst    = ~sy3[45];
    wire logic [31:0] b_ad     = sy3[44:13];
    wire logic [3:0]  b_cbe_b  = sy3[12:9];
    wire logic        b_par    = sy3[8];
    wire logic        b_frame  = ~sy3[7];
    wire logic        b_irdy   = ~sy3[6];
    wire logic        b_trdy   = ~sy3[5];
    wire logic        b_stop   = ~sy3[4];
    wire logic        b_devsel = ~sy3[3];
    wire logic        b_idsel  = sy3[2];
    wire logic        b_gnt    = ~sy3[1];

    pba_pkg::pba_tgt_e tst;
    pba_pkg::pba_mst_e mst;
    logic              f_q;
    logic              t_oe;
    logic              t_dev;
    logic              t_rdy;
    logic              t_stop;
    logic              t_ad_oe;
    logic [31:0]       t_ad;
    logic              m_req;
    logic              m_req_oe;
    logic              m_frame;
    logic              m_irdy;
    logic              m_ctl_oe;
    logic              m_ad_oe;
    logic              m_cbe_oe;
    logic [31:0]       m_ad;
    logic [3:0]        m_cbe;
    logic              m_wr;
    logic [31:0]       m_addr;
    logic [31:0]       m_wdata;
    logic [3:0]        m_be_b;
    logic [CW-1:0]     m_cnt;

    wire logic addr_ph = b_frame && !f_q;
    wire logic cfg_hit = (b_cbe_b == `PBA_CMD_CFGRD || b_cbe_b == `PBA_CMD_CFGWR)
                         && b_idsel && b_ad[1:0] == 2'h0;
    wire logic mem_hit = (b_cbe_b == `PBA_CMD_MRD || b_cbe_b == `PBA_CMD_MWR)
                         && (b_ad & BAR_MASK) == BAR_BASE;
    wire logic t_hit   = addr_ph && (cfg_hit || mem_hit) && mst == pba_pkg::M_IDLE;

    // Target: one data phase, disconnected with data by STOP together with TRDY.
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tst         <= pba_pkg::T_IDLE;
            t_oe        <= 1'b0;
            t_dev       <= 1'b0;
            t_rdy       <= 1'b0;
            t_stop      <= 1'b0;
            t_ad_oe     <= 1'b0;
            t_ad        <= 32'h0000_0000;
            o_tgt_stb   <= 1'b0;
            o_tgt_wr    <= 1'b0;
            o_tgt_cfg   <= 1'b0;
            o_tgt_addr  <= 32'h0000_0000;
            o_tgt_wdata <= 32'h0000_0000;
            o_tgt_be_b  <= 4'hF;
        end else begin
            o_tgt_stb <= 1'b0;
            if (b_rst) begin
                tst     <= pba_pkg::T_IDLE;
                t_oe    <= 1'b0;
                t_dev   <= 1'b0;
                t_rdy   <= 1'b0;
                t_stop  <= 1'b0;
                t_ad_oe <= 1'b0;
            end else if (rise) begin
                unique case (tst)
                    pba_pkg::T_IDLE: begin
                        t_oe <= 1'b0;
                        if (t_hit) begin
                            tst        <= pba_pkg::T_WAIT;
                            t_oe       <= 1'b1;
                            t_dev      <= 1'b1;
                            o_tgt_addr <= b_ad;
                            o_tgt_wr   <= b_cbe_b[0];
                            o_tgt_cfg  <= cfg_hit;
                        end
                    end
                    pba_pkg::T_WAIT: begin
                        tst    <= pba_pkg::T_DATA;
                        t_rdy  <= 1'b1;
                        t_stop <= 1'b1;
                        if (!o_tgt_wr) begin
                            t_ad      <= i_tgt_rdata;
                            t_ad_oe   <= 1'b1;
                            o_tgt_be_b <= b_cbe_b;
                            o_tgt_stb <= 1'b1;
                        end
                    end
                    pba_pkg::T_DATA: begin
                        if (b_irdy) begin
                            tst     <= pba_pkg::T_TURN;
                            t_rdy   <= 1'b0;
                            t_ad_oe <= 1'b0;
                            if (o_tgt_wr) begin
                                o_tgt_wdata <= b_ad;
                                o_tgt_be_b  <= b_cbe_b;
                                o_tgt_stb   <= 1'b1;
                            end
                        end
                    end
                    pba_pkg::T_TURN: begin
                        if (!b_frame) begin
                            tst    <= pba_pkg::T_IDLE;
                            t_dev  <= 1'b0;
                            t_stop <= 1'b0;
                        end
                    end
                endcase
            end
        end
    end

    // Master: request, grant, address phase, one data phase, abort on missing DEVSEL.
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mst         <= pba_pkg::M_IDLE;
            m_req       <= 1'b0;
            m_req_oe    <= 1'b0;
            m_frame     <= 1'b0;
            m_irdy      <= 1'b0;
            m_ctl_oe    <= 1'b0;
            m_ad_oe     <= 1'b0;
            m_cbe_oe    <= 1'b0;
            m_ad        <= 32'h0000_0000;
            m_cbe       <= 4'hF;
            m_wr        <= 1'b0;
            m_addr      <= 32'h0000_0000;
            m_wdata     <= 32'h0000_0000;
            m_be_b      <= 4'hF;
            m_cnt       <= '0;
            o_mst_done  <= 1'b0;
            o_mst_err   <= 1'b0;
            o_mst_rdata <= 32'h0000_0000;
        end else begin
            o_mst_done <= 1'b0;
            m_req_oe   <= !b_rst;
            if (b_rst) begin
                mst      <= pba_pkg::M_IDLE;
                m_req    <= 1'b0;
                m_frame  <= 1'b0;
                m_irdy   <= 1'b0;
                m_ctl_oe <= 1'b0;
                m_ad_oe  <= 1'b0;
                m_cbe_oe <= 1'b0;
            end else begin
                if (mst == pba_pkg::M_IDLE && i_mst_go) begin
                    mst       <= pba_pkg::M_REQ;
                    m_wr      <= i_mst_wr;
                    m_addr    <= i_mst_addr;
                    m_wdata   <= i_mst_wdata;
                    m_be_b    <= i_mst_be_b;
                    o_mst_err <= 1'b0;
                end
                if (rise) begin
                    unique case (mst)
                        pba_pkg::M_IDLE: begin
                            m_ctl_oe <= 1'b0;
                        end
                        pba_pkg::M_REQ: begin
                            m_req <= 1'b1;
                            if (m_req && b_gnt && !b_frame && !b_irdy && tst == pba_pkg::T_IDLE) begin
                                mst      <= pba_pkg::M_ADDR;
                                m_frame  <= 1'b1;
                                m_ctl_oe <= 1'b1;
                                m_ad     <= m_addr;
                                m_ad_oe  <= 1'b1;
                                m_cbe    <= m_wr ? `PBA_CMD_MWR : `PBA_CMD_MRD;
                                m_cbe_oe <= 1'b1;
                            end
                        end
                        pba_pkg::M_ADDR: begin
                            mst     <= pba_pkg::M_DATA;
                            m_frame <= 1'b0;
                            m_irdy  <= 1'b1;
                            m_req   <= 1'b0;
                            m_cbe   <= m_be_b;
                            m_cnt   <= '0;
                            m_ad    <= m_wdata;
                            m_ad_oe <= m_wr;
                        end
                        pba_pkg::M_DATA: begin
                            m_cnt <= m_cnt + 1'b1;
                            if (b_trdy || b_stop || (!b_devsel && m_cnt == CW'(MABORT - 1))) begin
                                mst         <= pba_pkg::M_IDLE;
                                m_irdy      <= 1'b0;
                                m_ad_oe     <= 1'b0;
                                m_cbe_oe    <= 1'b0;
                                o_mst_done  <= 1'b1;
                                o_mst_err   <= !b_trdy;
                                o_mst_rdata <= b_ad;
                            end
                        end
                    endcase
                end
            end
        end
    end

    // Parity generation, parity checks and the interrupt line.
    logic p_exp;
    logic a_chk;
    logic d_chk;
    logic serr;
    logic perr;
    logic perr_q;
    wire logic recv = (tst == pba_pkg::T_DATA && b_irdy && o_tgt_wr)
                      || (mst == pba_pkg::M_DATA && b_trdy && !m_wr);
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            f_q         <= 1'b0;
            p_exp       <= 1'b0;
            a_chk       <= 1'b0;
            d_chk       <= 1'b0;
            serr        <= 1'b0;
            perr        <= 1'b0;
            perr_q      <= 1'b0;
            o_par       <= 1'b0;
            o_par_oe_b  <= 1'b1;
            o_inta_oe_b <= 1'b1;
        end else begin
            o_inta_oe_b <= b_rst || ~|i_irq_src;
            if (b_rst) begin
                f_q        <= 1'b0;
                a_chk      <= 1'b0;
                d_chk      <= 1'b0;
                serr       <= 1'b0;
                perr       <= 1'b0;
                perr_q     <= 1'b0;
                o_par_oe_b <= 1'b1;
            end else if (rise) begin
                f_q        <= b_frame;
                p_exp      <= par36({b_ad, b_cbe_b});
                a_chk      <= addr_ph;
                d_chk      <= recv;
                serr       <= a_chk && b_par != p_exp;
                perr       <= d_chk && b_par != p_exp;
                perr_q     <= perr;
                o_par      <= par36({o_ad, m_cbe_oe ? m_cbe : b_cbe_b});
                o_par_oe_b <= o_ad_oe_b;
            end
        end
    end

    assign o_ad          = m_ad_oe ? m_ad : t_ad;
    assign o_ad_oe_b     = !(m_ad_oe || t_ad_oe);
    assign o_cbe_b       = m_cbe;
    assign o_cbe_oe_b    = !m_cbe_oe;
    assign o_frame_b     = !m_frame;
    assign o_irdy_b      = !m_irdy;
    assign o_frame_oe_b  = !m_ctl_oe;
    assign o_irdy_oe_b   = !m_ctl_oe;
    assign o_devsel_b    = !t_dev;
    assign o_trdy_b      = !t_rdy;
    assign o_stop_b      = !t_stop;
    assign o_devsel_oe_b = !t_oe;
    assign o_trdy_oe_b   = !t_oe;
    assign o_stop_oe_b   = !t_oe;
    assign o_req_b       = !m_req;
    assign o_req_oe_b    = !m_req_oe;
    assign o_perr_b      = !perr;
    assign o_perr_oe_b   = !(perr || perr_q);
    assign o_serr_b      = 1'b0;
    assign o_serr_oe_b   = !serr;
    assign o_inta_b      = 1'b0;
    assign o_mst_busy    = mst != pba_pkg::M_IDLE;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);

    sequence m_addr_s;
        rise && !b_rst && mst == pba_pkg::M_ADDR;
    endsequence
    sequence m_data_s;
        !o_irdy_b && o_frame_b && !o_frame_oe_b;
    endsequence

    par_value_a: assert property (rise && !b_rst && !o_ad_oe_b && !o_cbe_oe_b
        |=> o_par == (^$past(o_ad) ^ ^$past(o_cbe_b))) else $error("PAR not even parity");
    par_delay_a: assert property (rise && !b_rst && !o_ad_oe_b |=> !o_par_oe_b)
        else $error("PAR not driven one clock later");
    cbe_master_a: assert property (!o_cbe_oe_b |-> mst inside {pba_pkg::M_ADDR, pba_pkg::M_DATA})
        else $error("C/BE driven outside master cycle");
    req_float_a: assert property (b_rst |=> o_req_oe_b)
        else $error("REQ driven during bus reset");
    gnt_start_a: assert property ($rose(m_frame) |-> $past(b_gnt) && $past(m_req))
        else $error("FRAME started without grant");
    master_phase_a: assert property (m_addr_s |=> m_data_s)
        else $error("data phase not signalled");
    cfg_idsel_a: assert property (rise && !b_rst && tst == pba_pkg::T_IDLE && addr_ph && !b_idsel
        && (b_cbe_b == `PBA_CMD_CFGRD || b_cbe_b == `PBA_CMD_CFGWR) |=> tst == pba_pkg::T_IDLE)
        else $error("config cycle claimed without IDSEL");
    tgt_claim_a: assert property (rise && !b_rst && tst == pba_pkg::T_IDLE && !t_hit |=> o_devsel_oe_b)
        else $error("target signals driven unclaimed");
    trdy_devsel_a: assert property (!o_trdy_b || !o_stop_b |-> !o_devsel_b && !o_devsel_oe_b)
        else $error("TRDY or STOP without DEVSEL");
    serr_hold_a: assert property (rise && !b_rst && a_chk && b_par != p_exp |=> !o_serr_oe_b [*3])
        else $error("SERR missing on address parity error");
    perr_good_a: assert property (rise && !b_rst && d_chk && b_par == p_exp |=> o_perr_b)
        else $error("PERR on good parity");
    inta_level_a: assert property ((|i_irq_src) && !b_rst |=> !o_inta_oe_b)
        else $error("INTA not asserted");
    bus_reset_a: assert property (b_rst |=> tst == pba_pkg::T_IDLE && mst == pba_pkg::M_IDLE
        && o_frame_oe_b && o_devsel_oe_b) else $error("bus reset not idle");
    edge_only_a: assert property (!rise && !b_rst |=> $stable(o_frame_b) && $stable(o_devsel_b))
        else $error("bus signal changed off edge");
endmodule

// ### bench/pba_host.sv
// Partner model: host master, bus arbiter and memory target.
`timescale 1ns/10ps
module pba_host (
    // Bus clock and pin levels.
    input  wire logic        i_pci_clk,
    input  wire logic [31:0] i_ad,
    input  wire logic [3:0]  i_cbe_b,
    input  wire logic        i_frame_b,
    input  wire logic        i_trdy_b,
    input  wire logic        i_stop_b,
    input  wire logic        i_devsel_b,
    input  wire logic        i_req_b,
    // Partner drives.
    output logic      [31:0] o_h_ad,
    output logic      [3:0]  o_h_cbe,
    output logic             o_h_par,
    output logic             o_h_frame,
    output logic             o_h_irdy,
    output logic             o_h_trdy,
    output logic             o_h_devsel,
    output logic             o_h_gnt
);
    logic [31:0] d_ad, pat, t_rd, t_wd, t_ad;
    logic [3:0]  d_cbe, t_be;
    logic        d_par, own_ad, own_cbe, own_par, busy, t_on, t_wr, gnt_hold;
    // Released lines toggle every clock so that a stale value never passes as valid.
    assign o_h_ad = own_ad ? d_ad : pat;
    assign o_h_cbe = own_cbe ? d_cbe : pat[3:0];
    assign o_h_par = own_par ? d_par : pat[0];
    initial begin
        {pat, d_ad, d_cbe, d_par, own_ad, own_cbe, own_par, busy, t_on, gnt_hold} = '0;
        {o_h_frame, o_h_irdy, o_h_trdy, o_h_devsel, o_h_gnt} = '1;
    end
    always @(posedge i_pci_clk) begin
        pat <= ~pat;
        o_h_gnt <= i_req_b | gnt_hold | busy;
    end
    task automatic cyc(input logic [3:0] cmd, input logic [31:0] a, input logic [31:0] wd, input logic [3:0] be,
                       input logic [1:0] bad, output logic [31:0] rd, output logic hit);
        int n;
        busy = 1'b1;
        hit = 1'b0;
        @(posedge i_pci_clk);
        {o_h_frame, own_ad, own_cbe, d_ad, d_cbe} <= {3'b011, a, cmd};
        @(posedge i_pci_clk);
        {o_h_frame, o_h_irdy, own_par, d_par, d_cbe} <= {3'b101, ^{a, cmd} ^ bad[0], be};
        own_ad <= cmd[0];
        d_ad <= wd;
        for (n = 0; n < 9 && i_trdy_b && i_stop_b; n++) begin
            @(posedge i_pci_clk);
            own_par <= cmd[0];
            d_par <= ^{wd, be} ^ bad[1];
            hit |= !i_devsel_b;
        end
        rd = i_ad;
        {o_h_irdy, own_ad, own_cbe} <= 3'b100;
        @(posedge i_pci_clk);
        own_par <= 1'b0;
        busy = 1'b0;
    endtask
    // Memory target for the agent's own master cycles, one wait state.
    always @(posedge i_pci_clk) begin
        if (!i_frame_b && !busy && t_on) begin
            t_ad = i_ad;
            t_wr = i_cbe_b[0];
            o_h_devsel <= 1'b0;
            @(posedge i_pci_clk);
            {o_h_trdy, own_ad, d_ad} <= {1'b0, !t_wr, t_rd};
            @(posedge i_pci_clk);
            t_wd = i_ad;
            t_be = i_cbe_b;
            {o_h_trdy, o_h_devsel, own_ad, own_par, d_par} <= {3'b110, !t_wr, ^{t_rd, i_cbe_b}};
            @(posedge i_pci_clk);
            own_par <= 1'b0;
        end
    end
endmodule

// ### bench/tb.sv
// Self-checking bench for the bus agent.
`timescale 1ns/10ps
`include "pba_map.svh"
module tb;
    logic        i_sys_clk, i_rst_b, i_pci_clk, i_pci_rst_b, i_idsel, i_mst_go, i_mst_wr, i_par, i_frame_b;
    logic        i_irdy_b, i_trdy_b, i_stop_b, i_devsel_b, i_gnt_b, i_perr_b, i_req_b, o_par, o_ad_oe_b;
    logic [3:0]  i_cbe_b, i_irq_src, i_mst_be_b, o_cbe_b, o_tgt_be_b, o_h_cbe;
    logic [31:0] i_ad, i_tgt_rdata, i_mst_addr, i_mst_wdata, o_ad, o_tgt_addr, o_tgt_wdata, o_mst_rdata, o_h_ad, rd;
    logic        o_cbe_oe_b, o_par_oe_b, o_frame_b, o_frame_oe_b, o_irdy_b, o_irdy_oe_b, o_trdy_b, o_trdy_oe_b;
    logic        o_stop_b, o_stop_oe_b, o_devsel_b, o_devsel_oe_b, o_req_b, o_req_oe_b, o_perr_b, o_perr_oe_b;
    logic        o_serr_b, o_serr_oe_b, o_inta_b, o_inta_oe_b, o_tgt_stb, o_tgt_wr, o_tgt_cfg, o_mst_busy;
    logic        o_mst_done, o_mst_err, o_h_par, o_h_frame, o_h_irdy, o_h_trdy, o_h_devsel, o_h_gnt;
    logic        hit, pp, s_serr, s_perr;
    logic [69:0] tq[$], x;
    logic [33:0] mq[$], y;
    int          err_total, comparisons, seed, n, k;
    // Pins resolve to whoever enables them; STOP, PERR and REQ idle high on pull-ups.
    assign i_ad = o_ad_oe_b ? o_h_ad : o_ad;
    assign i_cbe_b = o_cbe_oe_b ? o_h_cbe : o_cbe_b;
    assign i_par = o_par_oe_b ? o_h_par : o_par;
    assign i_frame_b = o_frame_oe_b ? o_h_frame : o_frame_b;
    assign i_irdy_b = o_irdy_oe_b ? o_h_irdy : o_irdy_b;
    assign i_trdy_b = o_trdy_oe_b ? o_h_trdy : o_trdy_b;
    assign i_devsel_b = o_devsel_oe_b ? o_h_devsel : o_devsel_b;
    assign i_stop_b = o_stop_oe_b | o_stop_b;
    assign i_perr_b = o_perr_oe_b | o_perr_b;
    assign i_req_b = o_req_oe_b | o_req_b;
    assign i_gnt_b = o_h_gnt;
    pba_agent uut (.*);
    pba_host host (.*);
    initial begin
        i_sys_clk = 1'b0;
        forever #25 i_sys_clk = ~i_sys_clk;
    end
    initial begin
        i_pci_clk = 1'b0;
        #7;
        forever #200 i_pci_clk = ~i_pci_clk;
    end
    task automatic chk(input string nm, input logic [69:0] e, input logic [69:0] s);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wrap_up();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge i_sys_clk) begin
        s_serr <= s_serr | (o_serr_oe_b === 1'b0 && o_serr_b === 1'b0);
        s_perr <= s_perr | (o_perr_oe_b === 1'b0 && o_perr_b === 1'b0);
        if (o_tgt_stb === 1'b1) begin
            x = tq.size() ? tq.pop_front() : 'x;
            chk("target", x, {o_tgt_wr, o_tgt_cfg, o_tgt_addr, o_tgt_wr ? o_tgt_wdata : x[35:4], o_tgt_be_b});
        end
        if (o_mst_done === 1'b1) begin
            y = mq.size() ? mq.pop_front() : 'x;
            chk("master", y[32:0], {o_mst_err, y[33] ? o_mst_rdata : y[31:0]});
        end
    end
    always @(posedge i_pci_clk) begin
        if (o_par_oe_b === 1'b0) chk("parity", pp, i_par);
        pp = ^{i_ad, i_cbe_b};
    end
    task automatic bus(input logic [3:0] cmd, input logic [31:0] a, input logic sel, input logic [1:0] bad,
                       input logic take);
        logic [31:0] wd;
        logic [3:0]  be;
        wd = $random(seed);
        be = 4'($random(seed));
        @(negedge i_sys_clk);
        {s_serr, s_perr} = 2'b00;
        @(posedge i_sys_clk);
        i_idsel <= sel;
        i_tgt_rdata <= $random(seed);
        if (take) tq.push_back({cmd[0], cmd[3], a, wd, be});
        host.cyc(cmd, a, wd, be, bad, rd, hit);
        repeat (2) @(posedge i_pci_clk);
        chk("claim", take, hit);
        if (take && !cmd[0]) chk("rdata", i_tgt_rdata, rd);
        chk("release", 2'b11, {o_devsel_oe_b, o_trdy_oe_b});
        chk("errors", {bad[0], bad[1] & take}, {s_serr, s_perr});
    endtask
    task automatic mst(input logic wr, input logic on, input logic hold);
        host.gnt_hold = hold;
        host.t_on = on;
        host.t_rd = $random(seed);
        mq.push_back({!wr && on, !on, host.t_rd});
        @(posedge i_sys_clk);
        i_mst_go <= 1'b1;
        i_mst_wr <= wr;
        i_mst_addr <= $random(seed) & 32'hFFFF_FFFC;
        i_mst_wdata <= $random(seed);
        i_mst_be_b <= 4'($random(seed));
        @(posedge i_sys_clk);
        i_mst_go <= 1'b0;
        if (hold) begin
            repeat (60) @(posedge i_sys_clk);
            chk("nogrant", 2'b10, {o_frame_oe_b, o_req_b});
            host.gnt_hold = 1'b0;
        end
        @(negedge i_sys_clk);
        for (k = 0; k < 500 && o_mst_busy !== 1'b0; k++) @(posedge i_sys_clk);
        if (k == 500) begin
            err_total++;
            wrap_up();
        end
        repeat (2) @(posedge i_pci_clk);
        if (wr && on) chk("mwrite", {1'b1, i_mst_addr, i_mst_wdata, i_mst_be_b},
                          {host.t_wr, host.t_ad, host.t_wd, host.t_be});
    endtask
    initial begin
        seed = 57431;
        err_total = 0;
        comparisons = 0;
        {i_rst_b, i_pci_rst_b, i_idsel, i_mst_go, i_mst_wr, s_serr, s_perr} = '0;
        {i_tgt_rdata, i_mst_addr, i_mst_wdata, i_mst_be_b, i_irq_src} = '0;
        repeat (20) @(posedge i_sys_clk);
        chk("reqfloat", 1'b1, o_req_oe_b);
        i_rst_b <= 1'b1;
        i_pci_rst_b <= 1'b1;
        repeat (40) @(posedge i_sys_clk);
        bus(`PBA_CMD_CFGWR, 32'h0000_0010, 1'b1, 2'b00, 1'b1);
        bus(`PBA_CMD_CFGRD, 32'h0000_0024, 1'b1, 2'b00, 1'b1);
        bus(`PBA_CMD_CFGRD, 32'h0000_0024, 1'b0, 2'b00, 1'b0);
        for (n = 0; n < 4; n++) bus(n[0] ? `PBA_CMD_MWR : `PBA_CMD_MRD, `PBA_BAR_BASE | ($random(seed) & 32'hFFC),
                                    1'b0, 2'b00, 1'b1);
        bus(`PBA_CMD_MWR, `PBA_BAR_BASE + 32'h0000_1000, 1'b0, 2'b00, 1'b0);
        bus(4'h2, `PBA_BAR_BASE, 1'b0, 2'b00, 1'b0);
        bus(`PBA_CMD_MWR, 32'h0002_0000, 1'b0, 2'b01, 1'b0);
        bus(`PBA_CMD_MWR, `PBA_BAR_BASE, 1'b0, 2'b10, 1'b1);
        mst(1'b1, 1'b1, 1'b1);
        mst(1'b0, 1'b1, 1'b0);
        mst(1'b1, 1'b0, 1'b0);
        for (n = 0; n < 4; n++) begin
            @(posedge i_sys_clk);
            i_irq_src <= n[0] ? 4'h0 : 4'($random(seed));
            repeat (4) @(posedge i_sys_clk);
            chk("inta", {1'b0, i_irq_src === 4'h0}, {o_inta_b, o_inta_oe_b});
        end
        host.gnt_hold = 1'b1;
        @(posedge i_sys_clk);
        i_mst_go <= 1'b1;
        @(posedge i_sys_clk);
        i_mst_go <= 1'b0;
        repeat (40) @(posedge i_sys_clk);
        i_pci_rst_b <= 1'b0;
        repeat (10) @(posedge i_sys_clk);
        chk("busreset", 2'b10, {o_req_oe_b, o_mst_busy});
        host.gnt_hold = 1'b0;
        i_pci_rst_b <= 1'b1;
        repeat (40) @(posedge i_sys_clk);
        bus(`PBA_CMD_CFGWR, 32'h0000_0040, 1'b1, 2'b00, 1'b1);
        wrap_up();
    end
endmodule
